/* design/csst_channel_ctrl.sv */
// Per-channel start/hop synchronisation and memory/path self-test
//
// Summary of operation
// - Status bit 0 high while memory test runs.
// - Bit 1 coefficient fail, bit 2 sample fail.
// - Path test observes exactly the programmed output count.
// - Bits 7/6 pick external, random or sine input.
// - Soft sync bit wakes selected channels.
// - Separate in-phase and quadrature signatures.
// - Reset puts all channels to sleep.
// - Sleep bit per channel; clearing enables directly.
// - Soft start counts down, clears sleep at one.
// - Soft start latency is hold-off plus six.
// - Channel arms start on a chosen sync pin.
// - Pin start latency is hold-off plus three.
// - Zero frequency hold-off applies frequency immediately.
// - Soft hop counts down, loads frequency at one.
// - Soft hop latency is hold-off plus seven.
// - New frequency waits in shadow until expiry.
// - Pin hop latency is hold-off plus five.
`timescale 1ns/1ps
`default_nettype none
module csst_channel_ctrl (
   // Clock and reset
   input  wire logic                                mclk,
   input  wire logic                                rstn,
   // Host microport
   input  wire csst_pkg::csst_host_s                host,
   output logic      [31:0]                         rdata,
   // Sync pins and filter outputs
   input  wire logic [3:0]                          sync_pin,
   input  wire csst_pkg::csst_filt_s [3:0]          filt,
   // Channel outputs
   output wire logic [3:0]                          chan_sleep,
   output wire logic [3:0]                          chan_proc,
   output wire logic [3:0][31:0]                    osc_freq,
   output wire csst_pkg::csst_src_e [3:0]           test_src,
   output logic      [23:0]                         prng_data
);
   import csst_pkg::*;

   logic [31:0] rd_word [NCH];
   logic [7:0]  pin_word [NCH];
   logic        ext_wr;

   assign ext_wr = host.wr & host.ext;

   function automatic logic [19:0] sig_step(input logic [19:0] s, input logic [19:0] d);
      sig_step = {s[18:0], 1'b0} ^ (s[19] ? SIG_POLY : 20'h00000) ^ d;
   endfunction : sig_step

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic              ch_wr;
      logic              soft_start;
      logic              soft_hop;
      logic              pin_hit;
      logic              pin_start;
      logic              pin_hop;
      logic              sleep_reg;
      logic              proc_reg;
      logic [15:0]       sho_reg;
      logic [15:0]       fho_reg;
      logic [15:0]       scnt_reg;
      logic [15:0]       fcnt_reg;
      logic              srun_reg;
      logic              frun_reg;
      logic [3:0]        slat_reg;
      logic [3:0]        flat_reg;
      logic [3:0]        stail_reg;
      logic [3:0]        ftail_reg;
      logic [31:0]       shadow_reg;
      logic [31:0]       osc_reg;
      logic [3:0]        pin_en_reg;
      logic              arm_s_reg;
      logic              arm_h_reg;
      logic [19:0]       sig_i_reg;
      logic [19:0]       sig_q_reg;
      logic [19:0]       pctl_reg;
      logic [19:0]       pcnt_reg;
      logic [7:0]        src_reg;
      csst_src_e         src_sel_reg;
      csst_mb_e          mb_state_reg;
      logic [7:0]        mb_addr_reg;
      logic              mb_inv_reg;
      logic              cfail_reg;
      logic              dfail_reg;
      logic [19:0]       pat;
      logic [19:0]       coefficient_memory [COEFFICIENT_MEMORY_DEPTH];
      logic [39:0]       sample_memory [SAMPLE_MEMORY_DEPTH];

      assign ch_wr      = host.wr & ~host.ext & (host.chan == 2'(c));
      assign soft_start = ext_wr & (host.addr[2:0] == EXT_SYNC) & host.wdata[EXT5_SOFT_SYNC] & host.wdata[c];
      assign soft_hop   = ext_wr & (host.addr[2:0] == EXT_PIN) & (host.chan == 2'(c))
                          & host.wdata[EXT4_HOP] & host.wdata[EXT4_SYNC];
      assign pin_hit    = |(pin_en_reg & sync_pin);
      assign pin_start  = arm_s_reg & pin_hit;
      assign pin_hop    = arm_h_reg & pin_hit;
      assign pat        = {mb_addr_reg[3:0], mb_addr_reg, mb_addr_reg} ^ {20{mb_inv_reg}};

      // Host-written configuration
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            sho_reg     <= 16'h0000;
            fho_reg     <= 16'h0000;
            shadow_reg  <= 32'h00000000;
            src_reg     <= 8'h00;
            src_sel_reg <= SRC_EXT;
         end else if (ch_wr) begin
            if (host.addr == OFF_START_HO) sho_reg <= host.wdata[15:0];
            if (host.addr == OFF_FREQ_HO) fho_reg <= host.wdata[15:0];
            if (host.addr == OFF_FREQ) shadow_reg <= host.wdata;
            if (host.addr == OFF_SRC_SEL) begin
               src_reg <= host.wdata[7:0];
               if (host.wdata[SRC_PRNG_BIT]) src_sel_reg <= SRC_PRNG;
               else if (host.wdata[SRC_SINE_BIT]) src_sel_reg <= SRC_SINE;
               else src_sel_reg <= SRC_EXT;
            end
         end
      end

      // Pin-sync arming, one-shot per arm
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            pin_en_reg <= 4'h0;
            arm_s_reg  <= 1'b0;
            arm_h_reg  <= 1'b0;
         end else if (ext_wr && host.addr[2:0] == EXT_PIN && host.chan == 2'(c)) begin
            pin_en_reg <= host.wdata[3:0];
            arm_s_reg  <= host.wdata[EXT4_START_PIN];
            arm_h_reg  <= host.wdata[EXT4_HOP_PIN];
         end else if (pin_hit) begin
            arm_s_reg <= 1'b0;
            arm_h_reg <= 1'b0;
         end
      end

      // Start hold-off counter and post-expiry tail
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            srun_reg  <= 1'b0;
            scnt_reg  <= 16'h0000;
            slat_reg  <= 4'h0;
            stail_reg <= 4'h0;
         end else if (soft_start || pin_start) begin
            srun_reg <= 1'b1;
            scnt_reg <= sho_reg;
            slat_reg <= soft_start ? START_SOFT_LAT - 4'h1 : START_PIN_LAT - 4'h1;
         end else if (srun_reg) begin
            if (scnt_reg <= 16'h0001) begin
               srun_reg  <= 1'b0;
               stail_reg <= slat_reg;
            end else begin
               scnt_reg <= scnt_reg - 16'h0001;
            end
         end else if (stail_reg != 4'h0) begin
            stail_reg <= stail_reg - 4'h1;
         end
      end

      // Sleep bit: countdown expiry wins over a host write
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            sleep_reg <= SLEEP_RST;
            proc_reg  <= 1'b0;
         end else begin
            if (srun_reg && scnt_reg <= 16'h0001) sleep_reg <= 1'b0;
            else if (ext_wr && host.addr[2:0] == EXT_SLEEP) sleep_reg <= host.wdata[c];
            proc_reg <= ~sleep_reg & (stail_reg == 4'h0);
         end
      end

      // Frequency hold-off counter
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            frun_reg  <= 1'b0;
            fcnt_reg  <= 16'h0000;
            flat_reg  <= 4'h0;
            ftail_reg <= 4'h0;
         end else if (soft_hop || pin_hop) begin
            frun_reg <= 1'b1;
            fcnt_reg <= fho_reg;
            flat_reg <= soft_hop ? HOP_SOFT_LAT : HOP_PIN_LAT;
         end else if (frun_reg) begin
            if (fcnt_reg <= 16'h0001) begin
               frun_reg  <= 1'b0;
               ftail_reg <= flat_reg;
            end else begin
               fcnt_reg <= fcnt_reg - 16'h0001;
            end
         end else if (ftail_reg != 4'h0) begin
            ftail_reg <= ftail_reg - 4'h1;
         end
      end

      // Oscillator frequency load
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            osc_reg <= 32'h00000000;
         end else if (ftail_reg == 4'h1) begin
            osc_reg <= shadow_reg;
         end else if (ch_wr && host.addr == OFF_FREQ && fho_reg == 16'h0000 && !frun_reg) begin
            osc_reg <= host.wdata;
         end
      end

      // Path self-test signatures
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            sig_i_reg <= 20'h00000;
            sig_q_reg <= 20'h00000;
            pctl_reg  <= 20'h00000;
            pcnt_reg  <= 20'h00000;
         end else if (pcnt_reg != 20'h00000 && proc_reg && filt[c].valid) begin
            sig_i_reg <= sig_step(sig_i_reg, filt[c].i[23:4]);
            sig_q_reg <= sig_step(sig_q_reg, filt[c].q[23:4]);
            pcnt_reg  <= pcnt_reg - 20'h00001;
         end else if (ch_wr) begin
            if (host.addr == OFF_SIG_I) sig_i_reg <= host.wdata[19:0];
            if (host.addr == OFF_SIG_Q) sig_q_reg <= host.wdata[19:0];
            if (host.addr == OFF_PATH_CTL) begin
               pctl_reg <= host.wdata[19:0];
               pcnt_reg <= host.wdata[19:0];
            end
         end
      end

      // Memory self-test sequencer
      always_ff @(posedge mclk or negedge rstn) begin
         if (!rstn) begin
            mb_state_reg <= MB_IDLE;
            mb_addr_reg  <= 8'h00;
            mb_inv_reg   <= 1'b0;
            cfail_reg    <= 1'b0;
            dfail_reg    <= 1'b0;
         end else begin
            unique case (mb_state_reg)
               MB_IDLE: begin
                  if (ch_wr && host.addr == OFF_MEM_BIST && host.wdata[MB_BUSY]) begin
                     mb_state_reg <= MB_WRITE;
                     mb_addr_reg  <= 8'h00;
                     mb_inv_reg   <= 1'b0;
                     cfail_reg    <= 1'b0;
                     dfail_reg    <= 1'b0;
                  end
               end
               MB_WRITE: begin
                  mb_addr_reg <= mb_addr_reg + 8'h01;
                  if (mb_addr_reg == 8'hff) mb_state_reg <= MB_CHECK;
               end
               MB_CHECK: begin
                  mb_addr_reg <= mb_addr_reg + 8'h01;
                  if (coefficient_memory[mb_addr_reg] != pat) cfail_reg <= 1'b1;
                  if (mb_addr_reg < 8'(SAMPLE_MEMORY_DEPTH) && sample_memory[mb_addr_reg] != {pat, pat}) dfail_reg <= 1'b1;
                  if (mb_addr_reg == 8'hff) begin
                     mb_inv_reg   <= 1'b1;
                     mb_state_reg <= mb_inv_reg ? MB_IDLE : MB_WRITE;
                  end
               end
            endcase
         end
      end

      // Memory arrays under test
      always_ff @(posedge mclk) begin
         if (mb_state_reg == MB_WRITE) begin
            coefficient_memory[mb_addr_reg] <= pat;
            if (mb_addr_reg < 8'(SAMPLE_MEMORY_DEPTH)) sample_memory[mb_addr_reg] <= {pat, pat};
         end
      end

      // Read word for this channel
      always_comb begin
         rd_word[c] = 32'h00000000;
         unique case (host.addr)
            OFF_START_HO: rd_word[c] = {16'h0000, sho_reg};
            OFF_FREQ_HO:  rd_word[c] = {16'h0000, fho_reg};
            OFF_FREQ:     rd_word[c] = shadow_reg;
            OFF_SIG_I:    rd_word[c] = {12'h000, sig_i_reg};
            OFF_SIG_Q:    rd_word[c] = {12'h000, sig_q_reg};
            OFF_PATH_CTL: rd_word[c] = {12'h000, pctl_reg};
            OFF_MEM_BIST: rd_word[c] = {29'h0, dfail_reg, cfail_reg, mb_state_reg != MB_IDLE};
            OFF_SRC_SEL:  rd_word[c] = {24'h000000, src_reg};
            default:      rd_word[c] = 32'h00000000;
         endcase
      end

      assign pin_word[c]   = {2'b00, arm_h_reg, arm_s_reg, pin_en_reg};
      assign chan_sleep[c] = sleep_reg;
      assign chan_proc[c]  = proc_reg;
      assign osc_freq[c]   = osc_reg;
      assign test_src[c]   = src_sel_reg;
   end

   // Registered read data
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 32'h00000000;
      end else if (host.rd) begin
         if (!host.ext) rdata <= rd_word[host.chan];
         else if (host.addr[2:0] == EXT_SLEEP) rdata <= {28'h0000000, chan_sleep};
         else if (host.addr[2:0] == EXT_PIN) rdata <= {24'h000000, pin_word[host.chan]};
         else rdata <= 32'h00000000;
      end
   end

   // Shared pseudo-random test source
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) prng_data <= PRNG_SEED;
      else prng_data <= {prng_data[22:0], prng_data[23] ^ prng_data[22] ^ prng_data[21] ^ prng_data[16]};
   end
endmodule : csst_channel_ctrl
`default_nettype wire

/* include/csst_pkg.sv */
// Constants, types and carriers for the channel sync and self-test block
package csst_pkg;
   localparam int NCH = 4;
   localparam int COEFFICIENT_MEMORY_DEPTH = 256;
   localparam int SAMPLE_MEMORY_DEPTH = 160;
   // Channel register offsets
   localparam logic [7:0] OFF_START_HO = 8'h83;
   localparam logic [7:0] OFF_FREQ_HO  = 8'h84;
   localparam logic [7:0] OFF_FREQ     = 8'h85;
   localparam logic [7:0] OFF_SIG_I    = 8'ha5;
   localparam logic [7:0] OFF_SIG_Q    = 8'ha6;
   localparam logic [7:0] OFF_PATH_CTL = 8'ha7;
   localparam logic [7:0] OFF_MEM_BIST = 8'ha8;
   localparam logic [7:0] OFF_SRC_SEL  = 8'ha9;
   // External address registers
   localparam logic [2:0] EXT_SLEEP = 3'h3;
   localparam logic [2:0] EXT_PIN   = 3'h4;
   localparam logic [2:0] EXT_SYNC  = 3'h5;
   // Bit positions
   localparam int EXT5_SOFT_SYNC = 4;
   localparam int EXT4_START_PIN = 4;
   localparam int EXT4_HOP_PIN   = 5;
   localparam int EXT4_HOP       = 6;
   localparam int EXT4_SYNC      = 7;
   localparam int MB_BUSY        = 0;
   localparam int MB_CFAIL       = 1;
   localparam int MB_DFAIL       = 2;
   localparam int SRC_SINE_BIT   = 6;
   localparam int SRC_PRNG_BIT   = 7;
   // Latencies from trigger to processing (start) or frequency load (hop), master clocks
   localparam logic [3:0] START_SOFT_LAT = 4'h6;
   localparam logic [3:0] START_PIN_LAT  = 4'h3;
   localparam logic [3:0] HOP_SOFT_LAT   = 4'h7;
   localparam logic [3:0] HOP_PIN_LAT    = 4'h5;
   // Reset values and signature polynomial
   localparam logic        SLEEP_RST = 1'b1;
   localparam logic [23:0] PRNG_SEED = 24'h000001;
   localparam logic [19:0] SIG_POLY  = 20'h00009;

   typedef enum logic [2:0] {
      SRC_EXT  = 3'b001,
      SRC_PRNG = 3'b010,
      SRC_SINE = 3'b100
   } csst_src_e;

   typedef enum logic [2:0] {
      MB_IDLE  = 3'b001,
      MB_WRITE = 3'b010,
      MB_CHECK = 3'b100
   } csst_mb_e;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        ext;
      logic [1:0]  chan;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } csst_host_s;

   typedef struct packed {
      logic        valid;
      logic [23:0] i;
      logic [23:0] q;
   } csst_filt_s;
endpackage : csst_pkg

/* testbench/csst_host_model.sv */
// Host processor and sync pulse source in front of the block
`timescale 1ns/1ps
`default_nettype none
module csst_host_model (
   // Clock and read data
   input wire logic [31:0] rdata,
   input wire logic        mclk,
   // Bus and sync pins
   output var csst_pkg::csst_host_s host,
   output var logic [3:0]           sync_pin
);
   import csst_pkg::*;
   initial begin
      host = '0;
      sync_pin = 4'h0;
   end
   // One bus cycle; strobes drop to zero, other released fields show their inverse
   task automatic cycle(input logic w, input logic x, input logic [1:0] c,
                        input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      csst_host_s r;
      r = '{wr: w, rd: !w, ext: x, chan: c, addr: a, wdata: d};
      @(posedge mclk);
      host <= r;
      @(posedge mclk);
      host <= {2'b00, ~r[42:0]};
      #1;
      q = rdata;
   endtask : cycle
   // Sync pin high for one sampling edge
   task automatic pulse(input int p);
      @(posedge mclk);
      sync_pin[p] <= 1'b1;
      @(posedge mclk);
      sync_pin[p] <= 1'b0;
   endtask : pulse
endmodule : csst_host_model
`default_nettype wire

/* testbench/csst_channel_ctrl_monitor.sv */
// Concurrent checks on the ports of the channel sync and self-test block
`timescale 1ns/1ps
`default_nettype none
module csst_channel_ctrl_monitor (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Observed ports
   input wire csst_pkg::csst_host_s      host,
   input wire logic [31:0]               rdata,
   input wire logic [3:0]                chan_sleep,
   input wire logic [3:0]                chan_proc,
   input wire logic [3:0][31:0]          osc_freq,
   input wire csst_pkg::csst_src_e [3:0] test_src
);
   import csst_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic        wr0, rd0, ext_wr;
   logic [15:0] sho_reg, fho_reg;
   logic [31:0] shd_reg;
   logic [16:0] st_cnt_reg, hop_cnt_reg;
   logic [10:0] mb_cnt_reg;
   assign wr0 = host.wr && !host.ext && host.chan == 2'h0;
   assign rd0 = host.rd && !host.ext && host.chan == 2'h0 && host.addr == OFF_MEM_BIST;
   assign ext_wr = host.wr && host.ext;
   // Channel 0 hold-off values and pending frequency
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sho_reg <= 16'h0000;
         fho_reg <= 16'h0000;
         shd_reg <= 32'h0000_0000;
      end else if (wr0) begin
         if (host.addr == OFF_START_HO) sho_reg <= host.wdata[15:0];
         if (host.addr == OFF_FREQ_HO) fho_reg <= host.wdata[15:0];
         if (host.addr == OFF_FREQ) shd_reg <= host.wdata;
      end
   end
   // Cycles left to processing start, hop and memory test end on channel 0
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         st_cnt_reg <= 17'h0;
         hop_cnt_reg <= 17'h0;
         mb_cnt_reg <= 11'h0;
      end else begin
         st_cnt_reg <= (ext_wr && host.addr[2:0] == EXT_SYNC && host.wdata[4] && host.wdata[0]) ?
                       {1'b0, sho_reg} + 17'h6 : st_cnt_reg - {16'h0, st_cnt_reg != 17'h0};
         hop_cnt_reg <= (ext_wr && host.addr[2:0] == EXT_PIN && host.chan == 2'h0 && host.wdata[7:6] == 2'b11) ?
                        {1'b0, fho_reg} + 17'h7 : hop_cnt_reg - {16'h0, hop_cnt_reg != 17'h0};
         mb_cnt_reg <= (wr0 && host.addr == OFF_MEM_BIST && host.wdata[0] && mb_cnt_reg == 11'h0) ?
                       11'h400 : mb_cnt_reg - {10'h0, mb_cnt_reg != 11'h0};
      end
   end
   a_reset_asleep: assert property ($rose(rstn) |-> chan_sleep == 4'hf && chan_proc == 4'h0)
      else $error("channels not asleep after reset");
   a_proc_awake: assert property ((chan_proc & ~$past(chan_proc) & chan_sleep) == 4'h0)
      else $error("processing started while asleep");
   a_start_wake: assert property (st_cnt_reg == 17'h7 |-> chan_sleep[0] ##1 !chan_sleep[0])
      else $error("sleep not cleared at hold-off expiry");
   a_start_soft: assert property (st_cnt_reg == 17'h1 |-> !chan_proc[0] ##1 chan_proc[0])
      else $error("soft start latency wrong");
   a_hop_load: assert property (hop_cnt_reg == 17'h1 |=> osc_freq[0] == shd_reg)
      else $error("soft hop latency wrong");
   a_hop_hold: assert property (hop_cnt_reg > 17'h1 |=> $stable(osc_freq[0]))
      else $error("frequency changed before expiry");
   a_freq_direct: assert property (wr0 && host.addr == OFF_FREQ && fho_reg == 16'h0 && hop_cnt_reg == 17'h0
                                  |=> osc_freq[0] == $past(host.wdata))
      else $error("frequency not applied at once");
   a_bist_busy: assert property (rd0 && mb_cnt_reg > 11'd2 |=> rdata[0])
      else $error("memory test not busy");
   a_bist_done: assert property (rd0 && mb_cnt_reg == 11'h0 |=> rdata[2:0] == 3'b000)
      else $error("memory test status wrong");
   a_src_select: assert property (wr0 && host.addr == OFF_SRC_SEL |=> test_src[0] ==
                  ($past(host.wdata[7]) ? SRC_PRNG : $past(host.wdata[6]) ? SRC_SINE : SRC_EXT))
      else $error("test source selection wrong");
   a_sleep_write: assert property (ext_wr && host.addr[2:0] == EXT_SLEEP && st_cnt_reg == 17'h0
                                  |=> chan_sleep == $past(host.wdata[3:0]))
      else $error("sleep bits not written");
   c_soft_start: cover property (st_cnt_reg == 17'h1);
   c_soft_hop: cover property (hop_cnt_reg == 17'h1);
   c_bist_run: cover property (mb_cnt_reg == 11'h1);
endmodule : csst_channel_ctrl_monitor
bind csst_channel_ctrl csst_channel_ctrl_monitor u_monitor (.mclk(mclk), .rstn(rstn), .host(host),
   .rdata(rdata), .chan_sleep(chan_sleep), .chan_proc(chan_proc), .osc_freq(osc_freq), .test_src(test_src));
`default_nettype wire

/* testbench/csst_channel_ctrl_tb.sv */
// Self-checking testbench for the channel sync and self-test block
`timescale 1ns/1ps
`default_nettype none
module csst_channel_ctrl_tb;
   import csst_pkg::*;
   typedef struct {logic [7:0] addr; logic [31:0] wd; logic [31:0] exp;} csst_row_s;
   logic             mclk = 1'b0;
   logic             rstn = 1'b0;
   csst_host_s       host;
   logic [31:0]      rdata, rd_val;
   logic [3:0]       sync_pin, chan_sleep, chan_proc;
   csst_filt_s [3:0] filt = '0;
   logic [3:0][31:0] osc_freq;
   csst_src_e [3:0]  test_src;
   logic [19:0]      si, sq;
   logic [23:0]      di, prng_data;
   int               fails = 0;
   int               tests_run = 0;
   int               n;
   csst_row_s rows [10] = '{'{OFF_START_HO, 32'hffff_1234, 32'h1234}, '{OFF_FREQ_HO, 32'h1_abcd, 32'habcd},
      '{OFF_SIG_I, 32'hffff_ffff, 32'hf_ffff}, '{OFF_SIG_Q, 32'h0, 32'h0}, '{OFF_PATH_CTL, 32'h7_0003, 32'h7_0003},
      '{8'h10, 32'hffff_ffff, 32'h0}, '{OFF_SRC_SEL, 32'h0, 32'h1}, '{OFF_SRC_SEL, 32'h40, 32'h4},
      '{OFF_SRC_SEL, 32'h80, 32'h2}, '{OFF_SRC_SEL, 32'hc0, 32'h2}};
   always #10 mclk = ~mclk;
   csst_host_model hm (.mclk(mclk), .host(host), .rdata(rdata), .sync_pin(sync_pin));
   csst_channel_ctrl dut (.mclk(mclk), .rstn(rstn), .host(host), .rdata(rdata), .sync_pin(sync_pin),
      .filt(filt), .chan_sleep(chan_sleep), .chan_proc(chan_proc), .osc_freq(osc_freq),
      .test_src(test_src), .prng_data(prng_data));
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Count edges until processing starts or the frequency arrives
   task automatic lat_wait(input int c, input logic hop, input logic [31:0] f, inout int k);
      do begin
         @(posedge mclk);
         #1;
         k++;
      end while (k < 300 && (hop ? osc_freq[c] !== f : chan_proc[c] !== 1'b1));
      if (k >= 300) begin
         fails++;
         end_sim();
      end
   endtask : lat_wait
   task automatic push(input int c, input logic [23:0] i);
      @(posedge mclk);
      filt[c] <= '{valid: 1'b1, i: i, q: ~i};
      @(posedge mclk);
      filt[c].valid <= 1'b0;
   endtask : push
   function automatic logic [19:0] sig_step(input logic [19:0] s, input logic [23:0] d);
      return {s[18:0], 1'b0} ^ (s[19] ? SIG_POLY : 20'h0) ^ d[23:4];
   endfunction : sig_step
   initial begin
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      #1;
      check({chan_proc, chan_sleep}, 8'h0f);
      foreach (rows[k]) begin
         hm.cycle(1'b1, 1'b0, 2'h0, rows[k].addr, rows[k].wd, rd_val);
         hm.cycle(1'b0, 1'b0, 2'h0, rows[k].addr, 32'h0, rd_val);
         if (rows[k].addr == OFF_SRC_SEL) check(test_src[0], rows[k].exp);
         else check(rd_val, rows[k].exp);
      end
      hm.cycle(1'b1, 1'b0, 2'h0, OFF_MEM_BIST, 32'h1, rd_val);
      hm.cycle(1'b0, 1'b0, 2'h0, OFF_MEM_BIST, 32'h0, rd_val);
      check(rd_val[0], 1'b1);
      repeat (1600) @(posedge mclk);
      hm.cycle(1'b0, 1'b0, 2'h0, OFF_MEM_BIST, 32'h0, rd_val);
      check(rd_val, 32'h0);
      hm.cycle(1'b1, 1'b0, 2'h0, OFF_FREQ_HO, 32'h0, rd_val);
      hm.cycle(1'b1, 1'b0, 2'h0, OFF_FREQ, 32'h1234_5678, rd_val);
      check(osc_freq[0], 32'h1234_5678);
      hm.cycle(1'b1, 1'b0, 2'h0, OFF_START_HO, 32'h2, rd_val);
      hm.cycle(1'b1, 1'b0, 2'h3, OFF_START_HO, 32'h5, rd_val);
      hm.cycle(1'b1, 1'b1, 2'h0, {5'h0, EXT_SYNC}, 32'h19, rd_val);
      n = 0;
      lat_wait(0, 1'b0, 32'h0, n);
      check(n, 32'd8);
      lat_wait(3, 1'b0, 32'h0, n);
      check(n, 32'd11);
      hm.cycle(1'b1, 1'b0, 2'h0, OFF_FREQ_HO, 32'h4, rd_val);
      hm.cycle(1'b1, 1'b0, 2'h0, OFF_FREQ, 32'hcafe_0001, rd_val);
      check(osc_freq[0], 32'h1234_5678);
      hm.cycle(1'b1, 1'b1, 2'h0, {5'h0, EXT_PIN}, 32'hc0, rd_val);
      n = 0;
      lat_wait(0, 1'b1, 32'hcafe_0001, n);
      check(n, 32'd11);
      hm.cycle(1'b1, 1'b0, 2'h2, OFF_START_HO, 32'h3, rd_val);
      hm.cycle(1'b1, 1'b1, 2'h2, {5'h0, EXT_PIN}, 32'h14, rd_val);
      hm.pulse(2);
      n = 0;
      lat_wait(2, 1'b0, 32'h0, n);
      check(n, 32'd6);
      hm.cycle(1'b1, 1'b0, 2'h3, OFF_FREQ_HO, 32'h3, rd_val);
      hm.cycle(1'b1, 1'b0, 2'h3, OFF_FREQ, 32'h0bad_f00d, rd_val);
      hm.cycle(1'b1, 1'b1, 2'h3, {5'h0, EXT_PIN}, 32'h28, rd_val);
      hm.pulse(3);
      n = 0;
      lat_wait(3, 1'b1, 32'h0bad_f00d, n);
      check(n, 32'd8);
      hm.cycle(1'b1, 1'b0, 2'h1, OFF_START_HO, 32'h1, rd_val);
      hm.cycle(1'b1, 1'b0, 2'h1, OFF_SIG_I, 32'h0, rd_val);
      hm.cycle(1'b1, 1'b0, 2'h1, OFF_SIG_Q, 32'h0, rd_val);
      hm.cycle(1'b1, 1'b0, 2'h1, OFF_PATH_CTL, 32'h3, rd_val);
      hm.cycle(1'b1, 1'b1, 2'h0, {5'h0, EXT_SYNC}, 32'h12, rd_val);
      n = 0;
      lat_wait(1, 1'b0, 32'h0, n);
      check(n, 32'd7);
      si = 20'h0;
      sq = 20'h0;
      for (int k = 1; k <= 5; k++) begin
         di = 24'hc3_5a70 + 24'h10 * k;
         push(1, di);
         if (k <= 3) si = sig_step(si, di);
         if (k <= 3) sq = sig_step(sq, ~di);
      end
      hm.cycle(1'b0, 1'b0, 2'h1, OFF_SIG_I, 32'h0, rd_val);
      check(rd_val, {12'h0, si});
      hm.cycle(1'b0, 1'b0, 2'h1, OFF_SIG_Q, 32'h0, rd_val);
      check(rd_val, {12'h0, sq});
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      #1;
      check({chan_proc, chan_sleep}, 8'h0f);
      check(prng_data, {8'h00, PRNG_SEED});
      hm.cycle(1'b1, 1'b1, 2'h0, {5'h0, EXT_SLEEP}, 32'hb, rd_val);
      check(chan_sleep, 4'hb);
      hm.cycle(1'b0, 1'b1, 2'h0, {5'h0, EXT_SLEEP}, 32'h0, rd_val);
      check(rd_val, 32'hb);
      end_sim();
   end
endmodule : csst_channel_ctrl_tb
`default_nettype wire
